// ### mdic_cfg.svh
// offsets, field positions, reset values and vectors of the interrupt block
`ifndef MDIC_CFG_SVH
`define MDIC_CFG_SVH
// ****************************************************************
// register byte offsets on the bus
// ****************************************************************
`define MDIC_OFF_MASK 8'h00
`define MDIC_OFF_FORCE_CLR 8'h04
`define MDIC_OFF_SENSE_CTL 8'h08
`define MDIC_OFF_PERIPH_FLAGS 8'h0C
`define MDIC_OFF_SW_TRIP 8'h10
`define MDIC_OFF_PIN_EN_LOW 8'h14
`define MDIC_OFF_PIN_EN_HIGH 8'h18
`define MDIC_OFF_PIN_FLAGS_LOW 8'h1C
`define MDIC_OFF_PIN_FLAGS_HIGH 8'h20
`define MDIC_OFF_PIN_DIR 8'h24
`define MDIC_OFF_PIN_DATA 8'h28
`define MDIC_OFF_CORE_STATUS 8'h2C
// ****************************************************************
// field positions
// ****************************************************************
`define MDIC_MASK_PERIPH_BIT 9
`define MDIC_FC_FORCE_LSB 8
`define MDIC_CTL_SENSE_XREQ0 0
`define MDIC_CTL_SENSE_XREQ1 1
`define MDIC_CTL_SENSE_PERIPH 2
`define MDIC_CTL_NEST 4
`define MDIC_CORE_PERIPH 5
// ****************************************************************
// reset values
// ****************************************************************
`define MDIC_RST_MASK 10'h000
`define MDIC_RST_CTL 5'h00
`define MDIC_RST_PINS 9'h000
`define MDIC_RST_EDGE_SRC 13'h1C00
// ****************************************************************
// vector addresses
// ****************************************************************
`define MDIC_VEC_TRIP 14'h002C
`define MDIC_VEC_PERIPH 14'h0004
`define MDIC_VEC_SYNC 14'h000C
`define MDIC_VEC_PIN 14'h0008
`define MDIC_VEC_SW1 14'h0018
`define MDIC_VEC_SW0 14'h001C
`define MDIC_VEC_TX 14'h0020
`define MDIC_VEC_RX 14'h0024
`define MDIC_VEC_TIMER 14'h0028
`endif

// ### mdic_core_model.sv
// model of the program sequencer that takes interrupt requests
`timescale 1ns/1ns
module mdic_core_model import mdic_pkg::*; (
    // clock and reset
    input wire logic mclk_in,
    input wire logic rst_b_in,
    // request in, replies out
    input wire mdic_core_req_t core_req_in,
    output logic ack_out,
    output logic rti_out,
    output logic [13:0] last_vec_out
);
    logic [2:0] busy_q;
    // take a request, serve it a few cycles, then return
    // a level source still pending is simply taken again
    always_ff @(posedge mclk_in) begin
        ack_out <= 1'b0;
        rti_out <= 1'b0;
        if (!rst_b_in) begin
            busy_q <= 3'h0;
            last_vec_out <= 14'h0000;
        end else if (busy_q != 3'h0) begin
            busy_q <= busy_q - 3'h1;
            rti_out <= (busy_q == 3'h1);
        end else if (core_req_in.req === 1'b1) begin
            ack_out <= 1'b1;
            last_vec_out <= core_req_in.vector;
            busy_q <= 3'h4;
        end
    end
endmodule // mdic_core_model

// ### mdic_edge.sv
// edge detector comparing each level with its value one clock earlier
`timescale 1ns/1ns
module mdic_edge #(
    parameter int W = 1,
    parameter logic [W-1:0] RST_VAL = '0
) (
    // clock and reset
    input wire logic clk_in,
    input wire logic rst_b_in,
    // levels and edges
    input wire logic [W-1:0] level_in,
    output logic [W-1:0] rise_out,
    output logic [W-1:0] fall_out
);
    logic [W-1:0] prev_q;

    // previous sample; reset value matches the idle level of each line
    always_ff @(posedge clk_in) begin
        if (!rst_b_in) begin
            prev_q <= RST_VAL;
        end else begin
            prev_q <= level_in;
        end
    end

    assign rise_out = level_in & ~prev_q;
    assign fall_out = ~level_in & prev_q;
endmodule // mdic_edge

// ### mdic_pkg.sv
// types shared by the interrupt block
package mdic_pkg;
    // service slots, higher value is higher priority
    typedef enum logic [3:0] {
        SLOT_TIMER = 4'h0,
        SLOT_RX = 4'h1,
        SLOT_TX = 4'h2,
        SLOT_SW0 = 4'h3,
        SLOT_SW1 = 4'h4,
        SLOT_PIN = 4'h5,
        SLOT_SYNC = 4'h6,
        SLOT_PERIPH = 4'h7,
        SLOT_TRIP = 4'h8
    } mdic_slot_t;

    // request offered to the program sequencer
    typedef struct packed {
        logic req;
        mdic_slot_t slot;
        logic [13:0] vector;
    } mdic_core_req_t;
endpackage

// ### mdic_prio.sv
// priority encoder, the highest set bit wins
`timescale 1ns/1ns
module mdic_prio #(
    parameter int W = 9,
    parameter int IW = 4
) (
    // request vector
    input wire logic [W-1:0] req_in,
    // winner
    output logic valid_out,
    output logic [IW-1:0] idx_out
);
    // scan upward so the last hit, the highest, is kept
    always_comb begin
        idx_out = '0;
        for (int i = 0; i < W; i++) begin
            if (req_in[i]) begin
                idx_out = IW'(i);
            end
        end
    end

    assign valid_out = |req_in;
endmodule // mdic_prio

// ### mdic_top.sv
// interrupt control for the motor processor: peripheral line and core slots
//
// Decided for this implementation: the AXI4-Lite interface to the registers and the register offsets.
`timescale 1ns/1ns
`include "mdic_cfg.svh"
module mdic_top import mdic_pkg::*; #(
    parameter int ADDR_W = 8
) (
    // clock and reset
    input wire logic mclk_in,
    input wire logic rst_b_in,
    // axi4-lite write
    input wire logic s_axi_awvalid_in,
    output logic s_axi_awready_out,
    input wire logic [ADDR_W-1:0] s_axi_awaddr_in,
    input wire logic s_axi_wvalid_in,
    output logic s_axi_wready_out,
    input wire logic [31:0] s_axi_wdata_in,
    input wire logic [3:0] s_axi_wstrb_in,
    output logic s_axi_bvalid_out,
    input wire logic s_axi_bready_in,
    output logic [1:0] s_axi_bresp_out,
    // axi4-lite read
    input wire logic s_axi_arvalid_in,
    output logic s_axi_arready_out,
    input wire logic [ADDR_W-1:0] s_axi_araddr_in,
    output logic s_axi_rvalid_out,
    input wire logic s_axi_rready_in,
    output logic [31:0] s_axi_rdata_out,
    output logic [1:0] s_axi_rresp_out,
    // peripheral sources
    input wire logic pwm_sync_pulse_in,
    input wire logic pwm_trip_input_n_in,
    // general purpose pins
    input wire logic [8:0] general_purpose_pin_in,
    output logic [8:0] general_purpose_pin_out,
    output logic [8:0] general_purpose_pin_oe_n_out,
    // core sources
    input wire logic external_request_zero_n_in,
    input wire logic external_request_one_n_in,
    input wire logic sport_rx_evt_in,
    input wire logic sport_tx_evt_in,
    input wire logic timer_evt_in,
    // program sequencer
    input wire logic core_ack_in,
    input wire logic core_rti_in,
    output mdic_core_req_t core_req_out,
    output logic shared_peripheral_request_n_out
);
    // ****************************************************************
    // state
    // ****************************************************************
    logic [9:0] mask_q;
    logic [4:0] ctl_q;
    logic [8:0] pin_en_q, pin_dir_q, pin_dout_q, pin_flag_q, pin_oe_n_q;
    logic trip_flag_q, sync_flag_q, periph_n_q;
    logic [7:0] pend_q;
    logic [8:0] active_q;
    mdic_core_req_t core_req_q;
    logic aw_full_q, w_full_q, awready_q, wready_q, bvalid_q;
    logic arready_q, rvalid_q;
    logic [ADDR_W-1:0] aw_addr_q;
    logic [31:0] w_data_q, rdata_q;
    logic [3:0] w_strb_q;
    logic [1:0] bresp_q, rresp_q;

    // ****************************************************************
    // bus slave handshakes
    // ****************************************************************
    wire aw_take = s_axi_awvalid_in & awready_q;
    wire w_take = s_axi_wvalid_in & wready_q;
    wire wr_fire = aw_full_q & w_full_q & ~bvalid_q;
    wire aw_full_d = aw_take | (aw_full_q & ~wr_fire);
    wire w_full_d = w_take | (w_full_q & ~wr_fire);
    wire bvalid_d = wr_fire | (bvalid_q & ~s_axi_bready_in);
    wire ar_take = s_axi_arvalid_in & arready_q;
    wire rvalid_d = ar_take | (rvalid_q & ~s_axi_rready_in);
    wire [31:0] bmask = {{8{w_strb_q[3]}}, {8{w_strb_q[2]}},
                         {8{w_strb_q[1]}}, {8{w_strb_q[0]}}};
    wire [31:0] wd = w_data_q & bmask;
    wire [7:0] wa = aw_addr_q[7:0];
    wire [7:0] ra = s_axi_araddr_in[7:0];

    // write decode
    wire wr_mask = wr_fire & (wa == `MDIC_OFF_MASK);
    wire wr_fc = wr_fire & (wa == `MDIC_OFF_FORCE_CLR);
    wire wr_ctl = wr_fire & (wa == `MDIC_OFF_SENSE_CTL);
    wire wr_swt = wr_fire & (wa == `MDIC_OFF_SW_TRIP);
    wire wr_enl = wr_fire & (wa == `MDIC_OFF_PIN_EN_LOW);
    wire wr_enh = wr_fire & (wa == `MDIC_OFF_PIN_EN_HIGH);
    wire wr_dir = wr_fire & (wa == `MDIC_OFF_PIN_DIR);
    wire wr_dat = wr_fire & (wa == `MDIC_OFF_PIN_DATA);
    wire wr_ok = wr_mask | wr_fc | wr_ctl | wr_swt | wr_enl | wr_enh
                 | wr_dir | wr_dat;

    // read decode; read-to-clear acts in the cycle the address is taken
    wire rd_flags = ar_take & (ra == `MDIC_OFF_PERIPH_FLAGS);
    wire rd_pfl = ar_take & (ra == `MDIC_OFF_PIN_FLAGS_LOW);
    wire rd_pfh = ar_take & (ra == `MDIC_OFF_PIN_FLAGS_HIGH);
    wire [31:0] rd_mux =
        (ra == `MDIC_OFF_MASK) ? {22'h0, mask_q} :
        (ra == `MDIC_OFF_SENSE_CTL) ? {27'h0, ctl_q} :
        (ra == `MDIC_OFF_PERIPH_FLAGS) ? {30'h0, sync_flag_q, trip_flag_q} :
        (ra == `MDIC_OFF_PIN_EN_LOW) ? {24'h0, pin_en_q[7:0]} :
        (ra == `MDIC_OFF_PIN_EN_HIGH) ? {31'h0, pin_en_q[8]} :
        (ra == `MDIC_OFF_PIN_FLAGS_LOW) ? {24'h0, pin_flag_q[7:0]} :
        (ra == `MDIC_OFF_PIN_FLAGS_HIGH) ? {31'h0, pin_flag_q[8]} :
        (ra == `MDIC_OFF_PIN_DIR) ? {23'h0, pin_dir_q} :
        (ra == `MDIC_OFF_PIN_DATA) ? {23'h0, general_purpose_pin_in} :
        (ra == `MDIC_OFF_CORE_STATUS) ? {15'h0, active_q, pend_q} :
        32'h0;
    // write-only registers read as zero but answer okay
    wire rd_ok = (ra <= `MDIC_OFF_CORE_STATUS) & (ra[1:0] == 2'h0);

    // ****************************************************************
    // edge detection
    // ****************************************************************
    logic [12:0] src_rise, src_fall;
    logic line_fall;
    mdic_edge #(.W(13), .RST_VAL(`MDIC_RST_EDGE_SRC)) u_src_edge (
        .clk_in(mclk_in),
        .rst_b_in(rst_b_in),
        .level_in({external_request_one_n_in, external_request_zero_n_in,
                   pwm_trip_input_n_in, pwm_sync_pulse_in,
                   general_purpose_pin_in}),
        .rise_out(src_rise),
        .fall_out(src_fall)
    );
    mdic_edge #(.W(1), .RST_VAL(1'h1)) u_line_edge (
        .clk_in(mclk_in),
        .rst_b_in(rst_b_in),
        .level_in(periph_n_q),
        .rise_out(),
        .fall_out(line_fall)
    );

    // ****************************************************************
    // peripheral flags and shared line
    // ****************************************************************
    wire sync_rise = src_rise[9];
    wire trip_evt = src_fall[10] | wr_swt;
    // only enabled inputs report a change, either direction
    wire [8:0] pin_evt = (src_rise[8:0] | src_fall[8:0])
                         & pin_en_q & ~pin_dir_q;
    wire [8:0] pin_clr = {rd_pfh, {8{rd_pfl}}};
    wire [8:0] pin_live = pin_flag_q & pin_en_q;
    wire periph_any = trip_flag_q | sync_flag_q | (|pin_live);

    // set beats the read-clear, so an event in the read cycle survives
    wire trip_flag_d = (trip_flag_q & ~rd_flags) | trip_evt;
    wire sync_flag_d = (sync_flag_q & ~rd_flags) | sync_rise;
    wire [8:0] pin_flag_d = (pin_flag_q & ~pin_clr) | pin_evt;

    // ****************************************************************
    // core pending and selection
    // ****************************************************************
    wire xreq0_act = ~external_request_zero_n_in;
    wire xreq1_act = ~external_request_one_n_in;
    wire line_act = ~periph_n_q;
    wire sen0 = ctl_q[`MDIC_CTL_SENSE_XREQ0];
    wire sen1 = ctl_q[`MDIC_CTL_SENSE_XREQ1];
    wire sen2 = ctl_q[`MDIC_CTL_SENSE_PERIPH];
    wire nest_en = ctl_q[`MDIC_CTL_NEST];
    // edge sensitive sources latch; level sensitive ones follow the line
    wire [7:0] set_core = {2'h0, sen2 & line_fall, 2'h0,
                           sport_tx_evt_in | (sen1 & src_fall[12]),
                           sport_rx_evt_in | (sen0 & src_fall[11]),
                           timer_evt_in};
    // software slots 3 and 4 are set by force bits 11 and 12 only
    wire [7:0] fc_force = wr_fc ? wd[15:8] : 8'h00;
    wire [7:0] fc_clr = wr_fc ? wd[7:0] : 8'h00;
    wire [3:0] ack_slot = core_req_q.slot;
    wire [2:0] ack_bit = (ack_slot >= SLOT_PIN) ? 3'(`MDIC_CORE_PERIPH)
                                                : ack_slot[2:0];
    wire [7:0] ack_clr = core_ack_in ? (8'h01 << ack_bit) : 8'h00;
    wire [7:0] pend_d = (pend_q & ~(fc_clr | ack_clr)) | set_core | fc_force;
    wire [7:0] live = pend_q | {2'h0, ~sen2 & line_act, 2'h0,
                                ~sen1 & xreq1_act, ~sen0 & xreq0_act, 1'h0};

    // mask each slot; peripheral slots share mask bit 9
    wire p_en = live[`MDIC_CORE_PERIPH]
                & mask_q[`MDIC_MASK_PERIPH_BIT];
    wire s_trip = p_en & trip_flag_q;
    wire s_sync = p_en & sync_flag_q;
    wire s_pin = p_en & (|pin_live);
    wire [8:0] slot_req = {s_trip, p_en & ~(s_trip | s_sync | s_pin),
                           s_sync, s_pin, live[4:0] & mask_q[4:0]};
    logic cand_valid, act_valid;
    logic [3:0] cand_idx, act_idx;
    mdic_prio #(.W(9), .IW(4)) u_cand_prio (
        .req_in(slot_req),
        .valid_out(cand_valid),
        .idx_out(cand_idx)
    );
    mdic_prio #(.W(9), .IW(4)) u_act_prio (
        .req_in(active_q),
        .valid_out(act_valid),
        .idx_out(act_idx)
    );
    // no pre-emption unless nesting is on and the newcomer ranks higher
    wire allow = ~act_valid | (nest_en & (cand_idx > act_idx));
    wire [8:0] act_set = core_ack_in ? (9'h001 << ack_slot) : 9'h000;
    wire [8:0] act_clr = core_rti_in ? (9'h001 << act_idx) : 9'h000;
    wire [8:0] active_d = (active_q & ~act_clr) | act_set;

    // vector table by slot
    function automatic logic [13:0] vec_of(input logic [3:0] s);
        case (s)
            SLOT_TRIP: vec_of = `MDIC_VEC_TRIP;
            SLOT_PERIPH: vec_of = `MDIC_VEC_PERIPH;
            SLOT_SYNC: vec_of = `MDIC_VEC_SYNC;
            SLOT_PIN: vec_of = `MDIC_VEC_PIN;
            SLOT_SW1: vec_of = `MDIC_VEC_SW1;
            SLOT_SW0: vec_of = `MDIC_VEC_SW0;
            SLOT_TX: vec_of = `MDIC_VEC_TX;
            SLOT_RX: vec_of = `MDIC_VEC_RX;
            default: vec_of = `MDIC_VEC_TIMER;
        endcase
    endfunction
    wire mdic_core_req_t core_req_d = '{req: cand_valid & allow,
        slot: mdic_slot_t'(cand_idx), vector: vec_of(cand_idx)};

    // ****************************************************************
    // registers
    // ****************************************************************
    // bus slave
    always_ff @(posedge mclk_in) begin
        if (!rst_b_in) begin
            {aw_full_q, w_full_q, bvalid_q, rvalid_q} <= 4'h0;
            {awready_q, wready_q, arready_q} <= 3'h7;
            aw_addr_q <= '0;
            w_data_q <= 32'h0;
            w_strb_q <= 4'h0;
            {bresp_q, rresp_q} <= 4'h0;
            rdata_q <= 32'h0;
        end else begin
            {aw_full_q, w_full_q} <= {aw_full_d, w_full_d};
            {awready_q, wready_q} <= {~aw_full_d, ~w_full_d};
            if (aw_take) aw_addr_q <= s_axi_awaddr_in;
            if (w_take) {w_data_q, w_strb_q} <= {s_axi_wdata_in, s_axi_wstrb_in};
            bvalid_q <= bvalid_d;
            if (wr_fire) bresp_q <= wr_ok ? 2'h0 : 2'h2;
            rvalid_q <= rvalid_d;
            arready_q <= ~rvalid_d;
            if (ar_take) {rdata_q, rresp_q} <= {rd_mux, rd_ok ? 2'h0 : 2'h2};
        end
    end

    // configuration registers
    always_ff @(posedge mclk_in) begin
        if (!rst_b_in) begin
            mask_q <= `MDIC_RST_MASK;
            ctl_q <= `MDIC_RST_CTL;
            pin_en_q <= `MDIC_RST_PINS;
            pin_dir_q <= `MDIC_RST_PINS;
            pin_dout_q <= `MDIC_RST_PINS;
            pin_oe_n_q <= ~`MDIC_RST_PINS;
        end else begin
            if (wr_mask) mask_q <= (mask_q & ~bmask[9:0]) | wd[9:0];
            if (wr_ctl) ctl_q <= (ctl_q & ~bmask[4:0]) | wd[4:0];
            if (wr_enl) pin_en_q[7:0] <= wd[7:0] | (pin_en_q[7:0] & ~bmask[7:0]);
            if (wr_enh & w_strb_q[0]) pin_en_q[8] <= w_data_q[0];
            if (wr_dir) pin_dir_q <= (pin_dir_q & ~bmask[8:0]) | wd[8:0];
            if (wr_dir) pin_oe_n_q <= ~((pin_dir_q & ~bmask[8:0]) | wd[8:0]);
            if (wr_dat) pin_dout_q <= (pin_dout_q & ~bmask[8:0]) | wd[8:0];
        end
    end

    // flags, pending state and core request
    always_ff @(posedge mclk_in) begin
        if (!rst_b_in) begin
            {trip_flag_q, sync_flag_q} <= 2'h0;
            pin_flag_q <= 9'h000;
            periph_n_q <= 1'h1;
            pend_q <= 8'h00;
            active_q <= 9'h000;
            core_req_q <= '0;
        end else begin
            {trip_flag_q, sync_flag_q} <= {trip_flag_d, sync_flag_d};
            pin_flag_q <= pin_flag_d;
            periph_n_q <= ~periph_any;
            pend_q <= pend_d;
            active_q <= active_d;
            core_req_q <= core_req_d;
        end
    end

    // outputs straight from flops
    assign s_axi_awready_out = awready_q;
    assign s_axi_wready_out = wready_q;
    assign s_axi_bvalid_out = bvalid_q;
    assign s_axi_bresp_out = bresp_q;
    assign s_axi_arready_out = arready_q;
    assign s_axi_rvalid_out = rvalid_q;
    assign s_axi_rdata_out = rdata_q;
    assign s_axi_rresp_out = rresp_q;
    assign general_purpose_pin_out = pin_dout_q;
    assign general_purpose_pin_oe_n_out = pin_oe_n_q;
    assign core_req_out = core_req_q;
    assign shared_peripheral_request_n_out = periph_n_q;

    // ****************************************************************
    // assertions
    // ****************************************************************
    default clocking cb @(posedge mclk_in); endclocking
    default disable iff (!rst_b_in);

    pin_en_reset_a: assert property ($past(!rst_b_in) |-> pin_en_q == 9'h000)
        else $error("pin enables not cleared by reset");
    pin_dir_reset_a: assert property ($past(!rst_b_in) |->
        (pin_dir_q == 9'h000) && (&general_purpose_pin_oe_n_out))
        else $error("pins not inputs after reset");
    sync_rise_a: assert property ($rose(sync_flag_q) |-> $past(sync_rise))
        else $error("sync flag set without rising sync edge");
    trip_event_a: assert property (trip_evt |=> trip_flag_q)
        else $error("trip event did not set trip flag");
    pin_change_a: assert property (pin_evt != 9'h000 |=> |pin_flag_q)
        else $error("pin change not flagged");
    pin_gate_a: assert property ($rose(pin_flag_q[0]) |->
        $past(pin_en_q[0] & ~pin_dir_q[0]))
        else $error("pin flag from disabled or output pin");
    shared_line_a: assert property (shared_peripheral_request_n_out
        == !$past(periph_any))
        else $error("shared line does not follow pending flags");
    flag_clear_a: assert property (rd_flags && !trip_evt |=> !trip_flag_q)
        else $error("flag read did not clear trip flag");
    pin_clear_a: assert property (rd_pfl && !(|pin_evt[7:0])
        |=> pin_flag_q[7:0] == 8'h00)
        else $error("pin flag read did not clear");
    sw_force_a: assert property (wr_fc && wd[12] |=> pend_q[4])
        else $error("software interrupt one not forced");
    // the slot shown now was chosen a cycle ago; its mask bit must be set
    mask_gate_a: assert property (core_req_out.req |-> $past(
        (cand_idx >= SLOT_PIN) ? mask_q[`MDIC_MASK_PERIPH_BIT]
                               : mask_q[cand_idx[2:0]]))
        else $error("request for a masked source");
    no_nest_a: assert property (!nest_en && act_valid |=> !core_req_out.req)
        else $error("pre-emption while nesting off");
    prio_order_a: assert property (core_req_out.req
        && core_req_out.slot == SLOT_TIMER |-> $past(slot_req[8:1] == 8'h00))
        else $error("timer served over higher source");

    sync_seen_c: cover property (sync_rise ##1 !shared_peripheral_request_n_out);
    sw_trip_c: cover property (wr_swt ##[1:3] core_req_out.req);
    pin_flag_c: cover property (|pin_evt ##1 rd_pfl);
    nested_c: cover property (core_ack_in ##[1:20] core_ack_in && act_valid);
endmodule // mdic_top

// ### tb.sv
// self-checking bench for the interrupt block
`timescale 1ns/1ns
module tb import mdic_pkg::*;;
    logic clk = 0, rst_n = 0, awv = 0, wv = 0, br = 0, arv = 0, rr = 0;
    logic sync = 0, trip_n = 1, tmr = 0, x0_n = 1;
    logic [7:0] awa = 8'h00, ara = 8'h00;
    logic [31:0] wd = 32'h0, rd_d;
    logic [8:0] pins = 9'h000;
    logic [8:0] pout, poe_n;
    logic awr, wr_r, bv, arr, rv, spr_n, ack, rti;
    logic [1:0] bresp, rresp, rd_r, bq;
    logic [31:0] rdata;
    logic [13:0] vec;
    mdic_core_req_t creq;
    int num_errors = 0, tests_run = 0;
    // rows: address, expected data, expected response
    logic [41:0] rows [9] = '{{8'h00, 32'h0, 2'h0}, {8'h08, 32'h0, 2'h0},
        {8'h14, 32'h0, 2'h0}, {8'h18, 32'h0, 2'h0}, {8'h24, 32'h0, 2'h0},
        {8'h28, 32'h0, 2'h0}, {8'h2C, 32'h0, 2'h0}, {8'h04, 32'h0, 2'h0},
        {8'h40, 32'h0, 2'h2}};
    mdic_top u_dut (.mclk_in(clk), .rst_b_in(rst_n),
        .s_axi_awvalid_in(awv), .s_axi_awready_out(awr),
        .s_axi_awaddr_in(awa), .s_axi_wvalid_in(wv),
        .s_axi_wready_out(wr_r), .s_axi_wdata_in(wd),
        .s_axi_wstrb_in(4'hF), .s_axi_bvalid_out(bv),
        .s_axi_bready_in(br), .s_axi_bresp_out(bresp),
        .s_axi_arvalid_in(arv), .s_axi_arready_out(arr),
        .s_axi_araddr_in(ara), .s_axi_rvalid_out(rv),
        .s_axi_rready_in(rr), .s_axi_rdata_out(rdata),
        .s_axi_rresp_out(rresp), .pwm_sync_pulse_in(sync),
        .pwm_trip_input_n_in(trip_n), .general_purpose_pin_in(pins),
        .general_purpose_pin_out(pout), .general_purpose_pin_oe_n_out(poe_n),
        .external_request_zero_n_in(x0_n),
        .external_request_one_n_in(1'b1), .sport_rx_evt_in(1'b0),
        .sport_tx_evt_in(1'b0), .timer_evt_in(tmr), .core_ack_in(ack),
        .core_rti_in(rti), .core_req_out(creq),
        .shared_peripheral_request_n_out(spr_n));
    mdic_core_model u_core (.mclk_in(clk), .rst_b_in(rst_n),
        .core_req_in(creq), .ack_out(ack), .rti_out(rti),
        .last_vec_out(vec));
    // ****************************************************************
    // clock, verdict and watchdog
    // ****************************************************************
    initial begin
        forever #25 clk = ~clk;
    end
    task automatic summarize();
        if (num_errors == 0 && tests_run > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    initial begin
        #200000;
        num_errors++;
        summarize();
    end
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        tests_run++;
        if (g !== e) begin
            num_errors++;
            $display("Error t=%0t got %h exp %h", $time, g, e);
        end
    endtask
    // ****************************************************************
    // bus master tasks, entered just after a rising edge
    // ****************************************************************
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        bit a_ok = 0;
        bit d_ok = 0;
        awa <= a; wd <= d; awv <= 1; wv <= 1; br <= 1;
        // local flags: awv and wv still hold old values in this step
        while (!(a_ok && d_ok)) begin
            @(posedge clk);
            if (!a_ok && awr === 1'b1) begin
                a_ok = 1;
                awv <= 0;
            end
            if (!d_ok && wr_r === 1'b1) begin
                d_ok = 1;
                wv <= 0;
            end
        end
        do @(posedge clk); while (bv !== 1'b1);
        bq = bresp;
    endtask
    task automatic rd(input logic [7:0] a);
        ara <= a; arv <= 1; rr <= 1;
        do @(posedge clk); while (arr !== 1'b1);
        arv <= 0;
        do @(posedge clk); while (rv !== 1'b1);
        rd_d = rdata; rd_r = rresp;
    endtask
    task automatic idle(input int n);
        repeat (n) @(posedge clk);
    endtask
    // ****************************************************************
    // main sequence; control bit 2 stays clear, line level sensitive
    // ****************************************************************
    initial begin
        idle(10);
        rst_n <= 1;
        idle(1);
        foreach (rows[i]) begin
            rd(rows[i][41:34]);
            chk(rd_r, rows[i][1:0]);
            if (rows[i][1:0] == 2'h0) chk(rd_d, rows[i][33:2]);
        end
        chk(poe_n, 9'h1FF);
        chk(pout, 9'h000);
        // edge mode latches a one-cycle low pulse while still masked
        wr(8'h08, 32'h001);
        chk(bq, 2'h0);
        x0_n <= 0;
        idle(1);
        x0_n <= 1;
        idle(2);
        rd(8'h2C);
        chk(rd_d, 32'h2);
        wr(8'h08, 32'h000);
        wr(8'h04, 32'h002);
        rd(8'h2C);
        chk(rd_d, 32'h0);
        wr(8'h00, 32'h001);
        tmr <= 1;
        idle(1);
        tmr <= 0;
        idle(6);
        chk(vec, 14'h0028);
        wr(8'h00, 32'h011);
        wr(8'h04, 32'h1000);
        idle(6);
        chk(vec, 14'h0018);
        wr(8'h00, 32'h200);
        trip_n <= 0;
        idle(5);
        chk(spr_n, 1'b0);
        chk(vec, 14'h002C);
        rd(8'h0C);
        chk(rd_d, 32'h1);
        idle(3);
        chk(spr_n, 1'b1);
        wr(8'h10, 32'h1);
        sync <= 1;
        idle(4);
        chk(spr_n, 1'b0);
        rd(8'h0C);
        chk(rd_d, 32'h3);
        sync <= 0;
        idle(4);
        chk(spr_n, 1'b1);
        pins <= 9'h001;
        idle(4);
        rd(8'h1C);
        chk(rd_d, 32'h0);
        wr(8'h14, 32'h01);
        pins <= 9'h000;
        idle(5);
        chk(spr_n, 1'b0);
        chk(vec, 14'h0008);
        rd(8'h1C);
        chk(rd_d, 32'h1);
        // a rising change of the same pin is flagged too
        pins <= 9'h001;
        idle(3);
        rd(8'h1C);
        chk(rd_d, 32'h1);
        rd(8'h1C);
        chk(rd_d, 32'h0);
        summarize();
    end
endmodule // tb
